// ### common/oqb_pkg.sv
// constants and types for the overlap/queue bus idle state machine
package oqb_pkg;

  //////////////////////////////////////////////////////////////////////
  // clock and response timing
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned T_INTRQ_NS = 400;
  // longest time, so rounded down
  localparam int unsigned INTRQ_CYC = (T_INTRQ_NS * (CLK_HZ / 1_000_000)) / 1000;

  //////////////////////////////////////////////////////////////////////
  // apb register map (byte addresses)
  localparam int unsigned APB_AW = 8;
  localparam logic [APB_AW-1:0] ADDR_CTRL = 8'h00;
  localparam logic [APB_AW-1:0] ADDR_CMDS = 8'h04;
  localparam logic [APB_AW-1:0] ADDR_STAT = 8'h08;

  // control register fields
  localparam int unsigned CTRL_W = 16;
  localparam int unsigned CTRL_REL_BIT = 0;
  localparam int unsigned CTRL_SERV_BIT = 1;
  localparam int unsigned CTRL_DEV_BIT = 2;
  localparam int unsigned CTRL_QUEUE_BIT = 3;
  localparam int unsigned CTRL_TAG_LSB = 8;
  localparam int unsigned TAG_W = 8;
  localparam logic [CTRL_W-1:0] CTRL_RST = 16'h0000;

  // command code register: service code, then three queued-set codes
  localparam int unsigned CMDS_SVC_LSB = 0;
  localparam int unsigned CMDS_QA_LSB = 8;
  localparam int unsigned CMDS_QB_LSB = 16;
  localparam int unsigned CMDS_QC_LSB = 24;
  localparam logic [31:0] CMDS_RST = 32'h0000_0000;

  // status register fields
  localparam int unsigned STAT_STATE_LSB = 0;
  localparam int unsigned STAT_PEND_BIT = 4;
  localparam int unsigned STAT_NIEN_BIT = 5;
  localparam int unsigned STAT_SEL_BIT = 6;
  localparam int unsigned STAT_INTRQ_BIT = 7;

  //////////////////////////////////////////////////////////////////////
  // parallel port decode
  localparam logic [2:0] DA_STATUS_CMD = 3'h7;
  localparam logic [2:0] DA_DEVHEAD = 3'h6;
  localparam logic [2:0] DA_DEVCTRL = 3'h6;
  localparam int unsigned DEVHEAD_DEV_BIT = 4;
  localparam int unsigned DEVCTRL_NIEN_BIT = 1;

  // packed pin vector: strobes, chip selects, address, data
  localparam int unsigned PIN_W = 15;
  localparam int unsigned PIN_RD = 0;
  localparam int unsigned PIN_WR = 1;
  localparam int unsigned PIN_CS0 = 2;
  localparam int unsigned PIN_CS1 = 3;
  localparam int unsigned PIN_DA_LSB = 4;
  localparam int unsigned PIN_DD_LSB = 7;
  localparam logic [PIN_W-1:0] PIN_RST = 15'h000f;

  //////////////////////////////////////////////////////////////////////
  // idle states, gray along unsel-sir-sr-sis-ss-proto
  typedef enum logic [2:0] {
    ST_UNSEL = 3'h0,
    ST_SIR = 3'h1,
    ST_SR = 3'h3,
    ST_SIS = 3'h2,
    ST_SS = 3'h6,
    ST_PROTO = 3'h7
  } oqb_state_t;

endpackage

// ### verilog/oqb_pin_filter.sv
// three-stage pin synchroniser with second/third stage agreement
`timescale 1ns/1ns
`default_nettype none
module oqb_pin_filter #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  // raw pins
  input wire logic [WIDTH-1:0] pin_i,
  // filtered level and change-about-to-happen flag
  output logic [WIDTH-1:0] filt_o,
  output logic [WIDTH-1:0] chg_o
);

  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  logic [WIDTH-1:0] next_filt;

  // s1 feeds s2 only; nothing else may look at a metastable stage
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      chg_o[i] = (s2[i] == s3[i]) && (s3[i] != filt_o[i]);
      next_filt[i] = chg_o[i] ? s3[i] : filt_o[i];
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1 <= RST_VAL;
      s2 <= RST_VAL;
      s3 <= RST_VAL;
      filt_o <= RST_VAL;
    end else if (ce_i) begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
      filt_o <= next_filt;
    end
  end

endmodule
`default_nettype wire

// ### verilog/oqb_idle_fsm.sv
// device bus idle state machine for overlapped and queued commands
//
// Overview of operation
// - pending irq, nIEN 0, REL only: enter irq-released state, INTRQ on
// - command write there clears pending, drops INTRQ, starts protocol
// - status read in irq state clears pending, drops INTRQ, goes quiet
// - deselect in irq state releases INTRQ, goes to unselected idle
// - resume ready in irq-released state moves to irq-service state
// - no pending or nIEN 1, REL only: quiet released state, INTRQ low
// - command write in quiet released state starts that protocol
// - non-queued command with queue present aborts queue and command
// - deselect in quiet state goes unselected, INTRQ released
// - resume ready in quiet released: irq or quiet service per nIEN
// - pending irq, nIEN 0, SERV 1: irq-service state, INTRQ on
// - SERVICE in irq-service: load tag, drop INTRQ, service return
// - SERVICE in quiet service: load tag, go to service return
// - other command in service states starts it, INTRQ dropped
// - no pending or nIEN 1, SERV 1: quiet service state
// - deselected with REL or SERV: unselected idle, INTRQ released
// - select with pending, nIEN 0, REL only: assert INTRQ, irq-released
// - select without pending irq, REL only: quiet released state
// - select with pending, nIEN 0, SERV 1: assert INTRQ, irq-service
// - select without pending irq, SERV 1: quiet service state
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none
module oqb_idle_fsm (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [oqb_pkg::APB_AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // parallel host port pins
  input wire logic dior_n_i,
  input wire logic diow_n_i,
  input wire logic cs0_n_i,
  input wire logic cs1_n_i,
  input wire logic [2:0] da_i,
  input wire logic [7:0] dd_i,
  output logic intrq_o,
  output logic intrq_oe_o,
  output logic bsy_o,
  output logic drq_o,
  // device back end
  input wire logic done_i,
  input wire logic done_pend_i,
  input wire logic resume_i,
  output logic cmd_start_o,
  output logic svc_start_o,
  output logic abort_o,
  output logic [7:0] cmd_code_o,
  output logic [oqb_pkg::TAG_W-1:0] svc_tag_o
);
  import oqb_pkg::*;

  localparam int IRQ_LIM = INTRQ_CYC;

  //////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [PIN_W-1:0] pin_filt;
  logic [PIN_W-1:0] pin_chg;

  oqb_pin_filter #(
    .WIDTH(PIN_W),
    .RST_VAL(PIN_RST)
  ) u_pins (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .pin_i({dd_i, da_i, cs1_n_i, cs0_n_i, diow_n_i, dior_n_i}),
    .filt_o(pin_filt),
    .chg_o(pin_chg)
  );

  // address and data are settled long before the strobe negates
  logic rd_end, wr_end, cs0_sel, cs1_sel;
  logic [2:0] da;
  logic [7:0] dd;
  logic ev_rd_stat, ev_wr_cmd, ev_wr_dev, ev_wr_ctl, ev_done, ev_resume;

  //////////////////////////////////////////////////////////////////////
  // registers and state

  oqb_state_t state;
  oqb_state_t next_state;
  logic int_pend;
  logic next_int_pend;
  logic nien;
  logic next_nien;
  logic [CTRL_W-1:0] ctrl;
  logic [CTRL_W-1:0] next_ctrl;
  logic [31:0] cmds;
  logic [31:0] next_cmds;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, next_intrq, next_intrq_oe, next_bsy;
  logic next_cmd_start, next_svc_start, next_abort;
  logic [7:0] next_cmd_code;
  logic [TAG_W-1:0] next_svc_tag;
  logic set_serv, rel, serv, dev_this;

  function automatic oqb_state_t sel_target(input logic pend, input logic ien_n,
                                            input logic srv);
    logic irq;
    irq = pend && !ien_n;
    if (srv) begin
      sel_target = irq ? ST_SIS : ST_SS;
    end else begin
      sel_target = irq ? ST_SIR : ST_SR;
    end
  endfunction

  function automatic logic is_queued(input logic [7:0] code, input logic [31:0] set);
    is_queued = (code == set[CMDS_SVC_LSB +: 8]) || (code == set[CMDS_QA_LSB +: 8]) ||
                (code == set[CMDS_QB_LSB +: 8]) || (code == set[CMDS_QC_LSB +: 8]);
  endfunction

  //////////////////////////////////////////////////////////////////////
  // host access decode

  always_comb begin
    rd_end = pin_chg[PIN_RD] && !pin_filt[PIN_RD];
    wr_end = pin_chg[PIN_WR] && !pin_filt[PIN_WR];
    da = pin_filt[PIN_DA_LSB +: 3];
    dd = pin_filt[PIN_DD_LSB +: 8];
    cs0_sel = !pin_filt[PIN_CS0] && pin_filt[PIN_CS1];
    cs1_sel = pin_filt[PIN_CS0] && !pin_filt[PIN_CS1];
    ev_rd_stat = ce_i && rd_end && cs0_sel && (da == DA_STATUS_CMD);
    ev_wr_cmd = ce_i && wr_end && cs0_sel && (da == DA_STATUS_CMD);
    ev_wr_dev = ce_i && wr_end && cs0_sel && (da == DA_DEVHEAD);
    ev_wr_ctl = ce_i && wr_end && cs1_sel && (da == DA_DEVCTRL);
    ev_done = ce_i && done_i;
    ev_resume = ce_i && resume_i;
    rel = ctrl[CTRL_REL_BIT];
    serv = ctrl[CTRL_SERV_BIT];
    dev_this = dd[DEVHEAD_DEV_BIT] == ctrl[CTRL_DEV_BIT];
  end

  //////////////////////////////////////////////////////////////////////
  // idle state machine

  always_comb begin
    next_state = state;
    next_int_pend = int_pend;
    next_nien = nien;
    next_cmd_start = 1'b0;
    next_svc_start = 1'b0;
    next_abort = 1'b0;
    next_cmd_code = cmd_code_o;
    next_svc_tag = svc_tag_o;
    set_serv = 1'b0;
    if (ev_wr_ctl) begin
      next_nien = dd[DEVCTRL_NIEN_BIT];
    end
    case (state)
      ST_SIR, ST_SIS, ST_SR, ST_SS: begin
        if (ev_rd_stat && (state == ST_SIR || state == ST_SIS)) begin
          next_int_pend = 1'b0;
          next_state = (state == ST_SIR) ? ST_SR : ST_SS;
        end else if (ev_wr_dev && !dev_this) begin
          next_state = ST_UNSEL;
        end else if (ev_wr_cmd) begin
          next_int_pend = 1'b0;
          next_cmd_code = dd;
          next_state = ST_PROTO;
          if ((state == ST_SIS || state == ST_SS) && dd == cmds[CMDS_SVC_LSB +: 8]) begin
            next_svc_start = 1'b1;
            next_svc_tag = ctrl[CTRL_TAG_LSB +: TAG_W];
          end else if (ctrl[CTRL_QUEUE_BIT] && !is_queued(dd, cmds)) begin
            // host broke the queued-set discipline; the whole queue goes
            next_abort = 1'b1;
          end else begin
            next_cmd_start = 1'b1;
          end
        end else if (ev_resume && state == ST_SIR) begin
          next_state = ST_SIS;
          set_serv = 1'b1;
        end else if (ev_resume && state == ST_SR) begin
          next_state = next_nien ? ST_SS : ST_SIS;
          set_serv = 1'b1;
        end
      end
      ST_UNSEL: begin
        if (ev_wr_dev && dev_this && (rel || serv)) begin
          next_state = sel_target(int_pend, next_nien, serv);
        end
      end
      ST_PROTO: begin
        // host strobes other than a device control write are ignored here: the protocol owns the bus
        if (ev_done) begin
          next_int_pend = done_pend_i;
          next_state = sel_target(done_pend_i, next_nien, serv);
        end
      end
      default: begin
        next_state = ST_UNSEL;
      end
    endcase
    // intrq follows the state it lands in, so it moves in the same edge
    next_intrq = (next_state == ST_SIR) || (next_state == ST_SIS);
    next_intrq_oe = next_state != ST_UNSEL;
    next_bsy = next_state == ST_PROTO;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= ST_UNSEL;
      int_pend <= 1'b0;
      nien <= 1'b0;
      intrq_o <= 1'b0;
      intrq_oe_o <= 1'b0;
      bsy_o <= 1'b0;
      drq_o <= 1'b0;
      cmd_start_o <= 1'b0;
      svc_start_o <= 1'b0;
      abort_o <= 1'b0;
      cmd_code_o <= 8'h00;
      svc_tag_o <= 8'h00;
    end else if (ce_i) begin
      state <= next_state;
      int_pend <= next_int_pend;
      nien <= next_nien;
      intrq_o <= next_intrq;
      intrq_oe_o <= next_intrq_oe;
      bsy_o <= next_bsy;
      drq_o <= 1'b0;
      cmd_start_o <= next_cmd_start;
      svc_start_o <= next_svc_start;
      abort_o <= next_abort;
      cmd_code_o <= next_cmd_code;
      svc_tag_o <= next_svc_tag;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, so every access takes two access cycles

  always_comb begin
    next_pready = psel_i && penable_i && !pready_o;
    next_prdata = prdata_o;
    next_pslverr = 1'b0;
    next_ctrl = ctrl;
    next_cmds = cmds;
    if (next_pready) begin
      next_prdata = 32'h0000_0000;
      if (paddr_i == ADDR_CTRL) begin
        next_prdata[CTRL_W-1:0] = ctrl;
      end else if (paddr_i == ADDR_CMDS) begin
        next_prdata = cmds;
      end else if (paddr_i == ADDR_STAT) begin
        next_prdata[STAT_STATE_LSB +: 3] = state;
        next_prdata[STAT_PEND_BIT] = int_pend;
        next_prdata[STAT_NIEN_BIT] = nien;
        next_prdata[STAT_SEL_BIT] = state != ST_UNSEL;
        next_prdata[STAT_INTRQ_BIT] = intrq_o;
      end else begin
        next_pslverr = 1'b1;
      end
    end
    if (psel_i && penable_i && pready_o && pwrite_i) begin
      if (paddr_i == ADDR_CTRL) begin
        next_ctrl = pwdata_i[CTRL_W-1:0];
      end else if (paddr_i == ADDR_CMDS) begin
        next_cmds = pwdata_i;
      end
    end
    // hardware setting SERV beats a software clear in the same cycle
    if (set_serv) begin
      next_ctrl[CTRL_SERV_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl <= CTRL_RST;
      cmds <= CMDS_RST;
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else if (ce_i) begin
      ctrl <= next_ctrl;
      cmds <= next_cmds;
      prdata_o <= next_prdata;
      pready_o <= next_pready;
      pslverr_o <= next_pslverr;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_cmd_taken;
    ev_wr_cmd && (state != ST_UNSEL) && (state != ST_PROTO);
  endsequence

  sequence s_protocol_entered;
    bsy_o && (state == ST_PROTO) && !intrq_o && intrq_oe_o;
  endsequence

  a_irq_idle_out: assert property (
    (state == ST_SIR || state == ST_SIS) |-> intrq_o && intrq_oe_o && !bsy_o && !drq_o)
    else $error("irq idle state without intrq asserted");

  a_cmd_drops_irq: assert property (
    s_cmd_taken |=> s_protocol_entered ##0 !int_pend)
    else $error("command write did not drop intrq and pending");

  a_status_read_quiet: assert property (
    ev_rd_stat && (state == ST_SIR || state == ST_SIS) |=>
      !intrq_o && !int_pend && (state == ($past(state) == ST_SIR ? ST_SR : ST_SS)))
    else $error("status read did not quiet the device");

  a_intrq_budget: assert property (
    ev_rd_stat && intrq_o && (state != ST_PROTO) |-> ##[1:IRQ_LIM] !intrq_o)
    else $error("intrq not dropped within the response budget");

  a_deselect_release: assert property (
    ev_wr_dev && !dev_this && !ev_rd_stat && (state inside {ST_SIR, ST_SIS, ST_SR, ST_SS})
      |=> (state == ST_UNSEL) && !intrq_oe_o && !bsy_o && !drq_o)
    else $error("deselect did not release intrq");

  a_resume_service: assert property (
    ev_resume && (state == ST_SIR) && !ev_rd_stat && !ev_wr_dev && !ev_wr_cmd
      |=> (state == ST_SIS) && intrq_o && ctrl[CTRL_SERV_BIT])
    else $error("resume from irq released state missed service");

  a_resume_quiet: assert property (
    ev_resume && (state == ST_SR) && !ev_wr_dev && !ev_wr_cmd && !ev_wr_ctl
      |=> (state == ($past(nien) ? ST_SS : ST_SIS)) && (intrq_o == !$past(nien)))
    else $error("resume from quiet released state went wrong");

  a_service_tag: assert property (
    s_cmd_taken ##0 ((state == ST_SIS || state == ST_SS) && dd == cmds[CMDS_SVC_LSB +: 8])
      |=> svc_start_o && (svc_tag_o == $past(ctrl[CTRL_TAG_LSB +: TAG_W])) ##1 !svc_start_o)
    else $error("service command did not load tag");

  a_queue_abort: assert property (
    s_cmd_taken ##0 (ctrl[CTRL_QUEUE_BIT] && !is_queued(dd, cmds)) |=> abort_o && !cmd_start_o)
    else $error("non-queued command did not abort the queue");

  a_select_irq: assert property (
    ev_wr_dev && dev_this && (state == ST_UNSEL) && rel && !serv && int_pend && !nien
      && !ev_wr_ctl |=> (state == ST_SIR) && intrq_o && intrq_oe_o)
    else $error("select with pending interrupt did not assert intrq");

  a_deselect_quiet: assert property (
    ev_wr_dev && !dev_this && (state == ST_SR || state == ST_SS)
      |=> !intrq_o && (state == ST_UNSEL))
    else $error("deselect from quiet state changed intrq");

endmodule
`default_nettype wire

// ### bench/oqb_host_model.sv
// host adapter model driving the parallel port pins
`timescale 1ns/1ns
`default_nettype none
module oqb_host_model (
  // clock
  input wire logic clk_i,
  // host pins
  output logic dior_n_o,
  output logic diow_n_o,
  output logic cs0_n_o,
  output logic cs1_n_o,
  output logic [2:0] da_o,
  output logic [7:0] dd_o
);
  import oqb_pkg::*;
  logic [7:0] last_dd;
  initial begin
    dior_n_o = 1'b1;
    diow_n_o = 1'b1;
    cs0_n_o = 1'b1;
    cs1_n_o = 1'b1;
    da_o = 3'h0;
    dd_o = 8'hff;
    last_dd = 8'h00;
  end
  //////////////////////////////////////////////////////////////////////
  // one strobe; selects held for the whole response budget past the rise
  task automatic xfer(input logic rd, input logic cs0_n, input logic cs1_n,
      input logic [2:0] da, input logic [7:0] dd);
    repeat (3) @(posedge clk_i);
    cs0_n_o <= cs0_n;
    cs1_n_o <= cs1_n;
    da_o <= da;
    // reads leave the data lines undriven, shown as the inverse of the last byte
    dd_o <= rd ? ~last_dd : dd;
    if (!rd) last_dd = dd;
    @(posedge clk_i);
    dior_n_o <= !rd;
    diow_n_o <= rd;
    repeat (3) @(posedge clk_i);
    dior_n_o <= 1'b1;
    diow_n_o <= 1'b1;
    repeat (INTRQ_CYC) @(posedge clk_i);
    cs0_n_o <= 1'b1;
    cs1_n_o <= 1'b1;
    da_o <= ~da;
    dd_o <= ~last_dd;
  endtask
endmodule
`default_nettype wire

// ### bench/overlap_queue_bus_idle_fsm_bench.sv
// self-checking bench for the overlap/queue bus idle state machine
`timescale 1ns/1ns
`default_nettype none
module overlap_queue_bus_idle_fsm_bench;
  import oqb_pkg::*;
  typedef struct packed {
    logic [2:0] act;
    logic [7:0] arg;
    logic pend;
    oqb_state_t st;
    logic line;
    logic [1:0] pulse;
  } oqb_row_t;
  localparam int A_DH = 0, A_CMD = 1, A_RD = 2, A_DONE = 3, A_RES = 4, A_NIEN = 5, A_CTRL = 6;
  localparam int NR = 40;
  // walk through the idle states; arg of a ctrl row is the low byte, tag stays 8'h5a
  localparam oqb_row_t ROWS[NR] = '{
    '{A_DH,8'h00,0,ST_SR,0,0}, '{A_CMD,8'h60,0,ST_PROTO,0,1},
    '{A_DONE,8'h00,1,ST_SIR,1,0}, '{A_RD,8'h00,0,ST_SR,0,0},
    '{A_CMD,8'h61,0,ST_PROTO,0,1}, '{A_DONE,8'h00,1,ST_SIR,1,0},
    '{A_CMD,8'hc7,0,ST_PROTO,0,1}, '{A_DONE,8'h00,1,ST_SIR,1,0},
    '{A_DH,8'h01,0,ST_UNSEL,0,0}, '{A_DH,8'h00,0,ST_SIR,1,0},
    '{A_RES,8'h00,0,ST_SIS,1,0}, '{A_RD,8'h00,0,ST_SS,0,0},
    '{A_DH,8'h01,0,ST_UNSEL,0,0}, '{A_DH,8'h00,0,ST_SS,0,0},
    '{A_CMD,8'ha2,0,ST_PROTO,0,2}, '{A_CTRL,8'h03,0,ST_PROTO,0,0},
    '{A_DONE,8'h00,1,ST_SIS,1,0}, '{A_CMD,8'ha2,0,ST_PROTO,0,2},
    '{A_CTRL,8'h03,0,ST_PROTO,0,0}, '{A_DONE,8'h00,0,ST_SS,0,0},
    '{A_CMD,8'h61,0,ST_PROTO,0,1}, '{A_DONE,8'h00,1,ST_SIS,1,0},
    '{A_CMD,8'h60,0,ST_PROTO,0,1}, '{A_DONE,8'h00,1,ST_SIS,1,0},
    '{A_DH,8'h01,0,ST_UNSEL,0,0}, '{A_DH,8'h00,0,ST_SIS,1,0},
    '{A_RD,8'h00,0,ST_SS,0,0}, '{A_CTRL,8'h01,0,ST_SS,0,0},
    '{A_CMD,8'h60,0,ST_PROTO,0,1}, '{A_DONE,8'h00,0,ST_SR,0,0},
    '{A_RES,8'h00,0,ST_SIS,1,0}, '{A_RD,8'h00,0,ST_SS,0,0},
    '{A_CTRL,8'h01,0,ST_SS,0,0}, '{A_CMD,8'h60,0,ST_PROTO,0,1},
    '{A_DONE,8'h00,0,ST_SR,0,0}, '{A_NIEN,8'h01,0,ST_SR,0,0},
    '{A_RES,8'h00,0,ST_SS,0,0}, '{A_CTRL,8'h01,0,ST_SS,0,0},
    '{A_CMD,8'h60,0,ST_PROTO,0,1}, '{A_DONE,8'h00,1,ST_SR,0,0}
  };
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [APB_AW-1:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o;
  logic dior_n_i, diow_n_i, cs0_n_i, cs1_n_i;
  logic [2:0] da_i;
  logic [7:0] dd_i;
  logic intrq_o, intrq_oe_o, bsy_o, drq_o;
  logic done_i = 1'b0, done_pend_i = 1'b0, resume_i = 1'b0;
  logic ce_i = 1'b1;
  logic cmd_start_o, svc_start_o, abort_o;
  logic [7:0] cmd_code_o;
  logic [TAG_W-1:0] svc_tag_o;
  int n_fail = 0, compares = 0, n_cmd = 0, n_svc = 0, n_abt = 0;
  always #20 clk_i = ~clk_i;
  oqb_idle_fsm dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .dior_n_i(dior_n_i),
    .diow_n_i(diow_n_i), .cs0_n_i(cs0_n_i), .cs1_n_i(cs1_n_i), .da_i(da_i), .dd_i(dd_i),
    .intrq_o(intrq_o), .intrq_oe_o(intrq_oe_o), .bsy_o(bsy_o), .drq_o(drq_o),
    .done_i(done_i), .done_pend_i(done_pend_i), .resume_i(resume_i),
    .cmd_start_o(cmd_start_o), .svc_start_o(svc_start_o), .abort_o(abort_o),
    .cmd_code_o(cmd_code_o), .svc_tag_o(svc_tag_o));
  oqb_host_model host (.clk_i(clk_i), .dior_n_o(dior_n_i), .diow_n_o(diow_n_i),
    .cs0_n_o(cs0_n_i), .cs1_n_o(cs1_n_i), .da_o(da_i), .dd_o(dd_i));
  always @(posedge clk_i) begin
    if (cmd_start_o === 1'b1) n_cmd++;
    if (svc_start_o === 1'b1) n_svc++;
    if (abort_o === 1'b1) n_abt++;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t bit got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t word got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    // a slave that never answers is left to the watchdog
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic do_act(input oqb_row_t r);
    logic [31:0] d;
    logic e;
    case (r.act)
      A_DH: host.xfer(1'b0, 1'b0, 1'b1, DA_DEVHEAD, 8'(r.arg[0]) << DEVHEAD_DEV_BIT);
      A_CMD: host.xfer(1'b0, 1'b0, 1'b1, DA_STATUS_CMD, r.arg);
      A_RD: host.xfer(1'b1, 1'b0, 1'b1, DA_STATUS_CMD, 8'h00);
      A_NIEN: host.xfer(1'b0, 1'b1, 1'b0, DA_DEVCTRL, 8'(r.arg[0]) << DEVCTRL_NIEN_BIT);
      A_CTRL: apb(1'b1, ADDR_CTRL, {16'h0000, 8'h5a, r.arg}, d, e);
      default: begin
        @(posedge clk_i);
        done_i <= (r.act == A_DONE);
        resume_i <= (r.act == A_RES);
        done_pend_i <= r.pend;
        @(posedge clk_i);
        done_i <= 1'b0;
        resume_i <= 1'b0;
        repeat (2) @(posedge clk_i);
      end
    endcase
    #1;
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] rd;
    logic err;
    int c0, s0;
    repeat (8) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    apb(1'b0, ADDR_CTRL, 32'h0000_0000, rd, err);
    chk_word(rd, 32'(CTRL_RST));
    apb(1'b0, ADDR_STAT, 32'h0000_0000, rd, err);
    chk_word(rd, 32'h0000_0000);
    chk_bit(intrq_oe_o, 1'b0);
    apb(1'b1, ADDR_STAT, 32'h0000_00ff, rd, err);
    apb(1'b0, ADDR_STAT, 32'h0000_0000, rd, err);
    chk_word(rd, 32'h0000_0000);
    apb(1'b0, 8'h0c, 32'h0000_0000, rd, err);
    chk_bit(err, 1'b1);
    apb(1'b1, ADDR_CMDS, 32'hc761_60a2, rd, err);
    apb(1'b0, ADDR_CMDS, 32'h0000_0000, rd, err);
    chk_word(rd, 32'hc761_60a2);
    chk_bit(err, 1'b0);
    apb(1'b1, ADDR_CTRL, 32'h0000_5a01, rd, err);
    $display("test registers done");
    for (int i = 0; i < NR; i++) begin
      c0 = n_cmd;
      s0 = n_svc;
      do_act(ROWS[i]);
      chk_bit(intrq_o & intrq_oe_o, ROWS[i].line);
      if (ROWS[i].st == ST_UNSEL) chk_bit(intrq_oe_o, 1'b0);
      chk_bit(bsy_o, ROWS[i].st == ST_PROTO);
      chk_bit(drq_o, 1'b0);
      chk_word(32'(n_cmd - c0), 32'(ROWS[i].pulse == 2'd1));
      chk_word(32'(n_svc - s0), 32'(ROWS[i].pulse == 2'd2));
      if (ROWS[i].pulse == 2'd1) chk_word(32'(cmd_code_o), 32'(ROWS[i].arg));
      if (ROWS[i].pulse == 2'd2) chk_word(32'(svc_tag_o), 32'h0000_005a);
      apb(1'b0, ADDR_STAT, 32'h0000_0000, rd, err);
      chk_word(32'(rd[2:0]), 32'(ROWS[i].st));
    end
    $display("test idle walk done");
    // queue present: a code outside the queued set aborts the queue
    apb(1'b1, ADDR_CTRL, 32'h0000_5a09, rd, err);
    c0 = n_abt;
    do_act('{A_CMD, 8'h20, 1'b0, ST_SR, 1'b0, 2'd0});
    chk_word(32'(n_abt - c0), 32'h0000_0001);
    chk_word(32'(cmd_code_o), 32'h0000_0020);
    $display("test queue abort done");
    // enable low: a completion pulse must be lost, protocol stays busy
    @(posedge clk_i);
    ce_i <= 1'b0;
    done_i <= 1'b1;
    done_pend_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    done_i <= 1'b0;
    @(posedge clk_i);
    ce_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    chk_bit(bsy_o, 1'b1);
    chk_bit(intrq_o, 1'b0);
    $display("test clock enable done");
    @(posedge clk_i);
    arst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk_bit(intrq_oe_o | bsy_o | cmd_start_o, 1'b0);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    apb(1'b0, ADDR_STAT, 32'h0000_0000, rd, err);
    chk_word(rd, 32'h0000_0000);
    $display("test mid reset done");
    close_out();
  end
  initial begin
    #(40 * 20000);
    n_fail++;
    $display("MISMATCH %0t watchdog expired", $time);
    close_out();
  end
endmodule
`default_nettype wire
